// ---- hw/rotate_shift_subtract_alu.sv ----
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/10ps

module rotate_shift_subtract_alu
(
	input  wire logic       clk_sys,
	input  wire logic       sys_rst,
	input  wire logic       opValid,
	input  wire logic [7:0] opCode,
	input  wire logic [7:0] dstIn,
	input  wire logic [7:0] srcIn,
	input  wire logic       extIrq,
	input  wire logic [3:0] regAddr,
	input  wire logic [7:0] regWrData,
	input  wire logic       regWrEn,
	input  wire logic       regRdEn,
	output logic      [7:0] regRdData,
	output logic      [7:0] resultData,
	output logic            resultValid,
	output logic      [7:0] flagsOut,
	output logic      [7:0] winPtrA,
	output logic      [7:0] winPtrB,
	output logic            stopMode
);

	typedef struct packed
	{
		logic [7:0] flags;
		logic [7:0] ptrA;
		logic [7:0] ptrB;
		logic       stop;
		logic [7:0] result;
		logic       resValid;
		logic [7:0] rdData;
		logic       irqMeta;
		logic       irqSync;
	} state_s;

	localparam state_s STATE_RST = '{
		flags:    alu_slice_pkg::FLAGS_RST,
		ptrA:     alu_slice_pkg::PTR_A_RST,
		ptrB:     alu_slice_pkg::PTR_B_RST,
		stop:     1'b0,
		result:   8'h00,
		resValid: 1'b0,
		rdData:   8'h00,
		irqMeta:  1'b0,
		irqSync:  1'b0
	};

	state_s     state_q;
	state_s     state_d;
	logic       opGo;
	logic       withCarry;
	logic       borrowIn;
	logic [8:0] diffFull;
	logic [4:0] diffLow;

	assign opGo = opValid && !state_q.stop;

	// Subtract forms: dst + ~src + 1 - borrow, bit 8 is the borrow out
	assign withCarry = (opCode[7:4] == alu_slice_pkg::OP_MINUS_CY_LO[7:4]);
	assign borrowIn  = withCarry && state_q.flags[alu_slice_pkg::FLAG_CY];
	assign diffFull  = {1'b0, dstIn} - {1'b0, srcIn} - {8'h00, borrowIn};
	assign diffLow   = {1'b0, dstIn[3:0]} - {1'b0, srcIn[3:0]} - {4'h0, borrowIn};

	always_comb
	begin
		state_d          = state_q;
		state_d.resValid = 1'b0;
		state_d.rdData   = 8'h00;
		state_d.irqMeta  = extIrq;
		state_d.irqSync  = state_q.irqMeta;

		// Register port; writes are ignored while stopped so state is retained
		if (regWrEn && !state_q.stop)
		begin
			unique case (regAddr)
				alu_slice_pkg::REG_FLAGS: state_d.flags = regWrData;
				alu_slice_pkg::REG_PTR_A: state_d.ptrA  = regWrData;
				alu_slice_pkg::REG_PTR_B: state_d.ptrB  = regWrData;
				default: ;
			endcase
		end
		if (regRdEn)
		begin
			unique case (regAddr)
				alu_slice_pkg::REG_FLAGS:  state_d.rdData = state_q.flags;
				alu_slice_pkg::REG_PTR_A:  state_d.rdData = state_q.ptrA;
				alu_slice_pkg::REG_PTR_B:  state_d.rdData = state_q.ptrB;
				alu_slice_pkg::REG_STATUS: state_d.rdData = {7'h00, state_q.stop};
				default:                   state_d.rdData = 8'h00;
			endcase
		end

		if (state_q.stop)
		begin
			if (state_q.irqSync)
				state_d.stop = 1'b0;
		end
		else if (opValid)
		begin
			unique case (opCode) inside
				alu_slice_pkg::OP_ROT_PLAIN_R, alu_slice_pkg::OP_ROT_PLAIN_IR:
				begin
					state_d.result = {dstIn[0], dstIn[7:1]};
					state_d.resValid = 1'b1;
					state_d.flags[alu_slice_pkg::FLAG_CY] = dstIn[0];
					state_d.flags[alu_slice_pkg::FLAG_ZE] = ({dstIn[0], dstIn[7:1]} == 8'h00);
					state_d.flags[alu_slice_pkg::FLAG_SG] = dstIn[0];
					state_d.flags[alu_slice_pkg::FLAG_OV] = dstIn[7] ^ dstIn[0];
				end
				alu_slice_pkg::OP_ROT_CY_R, alu_slice_pkg::OP_ROT_CY_IR:
				begin
					state_d.result = {state_q.flags[alu_slice_pkg::FLAG_CY], dstIn[7:1]};
					state_d.resValid = 1'b1;
					state_d.flags[alu_slice_pkg::FLAG_CY] = dstIn[0];
					state_d.flags[alu_slice_pkg::FLAG_ZE] =
						({state_q.flags[alu_slice_pkg::FLAG_CY], dstIn[7:1]} == 8'h00);
					state_d.flags[alu_slice_pkg::FLAG_SG] = state_q.flags[alu_slice_pkg::FLAG_CY];
					state_d.flags[alu_slice_pkg::FLAG_OV] =
						dstIn[7] ^ state_q.flags[alu_slice_pkg::FLAG_CY];
				end
				alu_slice_pkg::OP_ASHIFT_R, alu_slice_pkg::OP_ASHIFT_IR:
				begin
					state_d.result = {dstIn[7], dstIn[7:1]};
					state_d.resValid = 1'b1;
					state_d.flags[alu_slice_pkg::FLAG_CY] = dstIn[0];
					state_d.flags[alu_slice_pkg::FLAG_ZE] = (dstIn[7:1] == 7'h00);
					state_d.flags[alu_slice_pkg::FLAG_SG] = dstIn[7];
					state_d.flags[alu_slice_pkg::FLAG_OV] = 1'b0;
				end
				alu_slice_pkg::OP_SWAP_R, alu_slice_pkg::OP_SWAP_IR:
				begin
					// Carry and overflow are undefined; they keep their old value
					state_d.result = {dstIn[3:0], dstIn[7:4]};
					state_d.resValid = 1'b1;
					state_d.flags[alu_slice_pkg::FLAG_ZE] = (dstIn == 8'h00);
					state_d.flags[alu_slice_pkg::FLAG_SG] = dstIn[3];
				end
				[alu_slice_pkg::OP_MINUS_LO : alu_slice_pkg::OP_MINUS_HI],
				[alu_slice_pkg::OP_MINUS_CY_LO : alu_slice_pkg::OP_MINUS_CY_HI]:
				begin
					state_d.result = diffFull[7:0];
					state_d.resValid = 1'b1;
					state_d.flags[alu_slice_pkg::FLAG_CY] = diffFull[8];
					state_d.flags[alu_slice_pkg::FLAG_ZE] = (diffFull[7:0] == 8'h00);
					state_d.flags[alu_slice_pkg::FLAG_SG] = diffFull[7];
					state_d.flags[alu_slice_pkg::FLAG_OV] =
						(dstIn[7] != srcIn[7]) && (diffFull[7] == srcIn[7]);
					state_d.flags[alu_slice_pkg::FLAG_DA] = 1'b1;
					state_d.flags[alu_slice_pkg::FLAG_HC] = diffLow[4];
				end
				alu_slice_pkg::OP_BANK_ZERO:
					state_d.flags[alu_slice_pkg::FLAG_BANK] = 1'b0;
				alu_slice_pkg::OP_BANK_ONE:
					state_d.flags[alu_slice_pkg::FLAG_BANK] = 1'b1;
				alu_slice_pkg::OP_CY_HIGH:
					state_d.flags[alu_slice_pkg::FLAG_CY] = 1'b1;
				alu_slice_pkg::OP_WIN_PTR_LOAD:
				begin
					unique case (srcIn[1:0])
						alu_slice_pkg::SEL_PTR_A:
							state_d.ptrA[7:3] = srcIn[7:3];
						alu_slice_pkg::SEL_PTR_B:
							state_d.ptrB[7:3] = srcIn[7:3];
						alu_slice_pkg::SEL_BOTH:
						begin
							state_d.ptrA[7:3] = {srcIn[7:4], 1'b0};
							state_d.ptrB[7:3] = {srcIn[7:4], 1'b1};
						end
						default: ;
					endcase
				end
				alu_slice_pkg::OP_HALT:
					state_d.stop = 1'b1;
				default: ;
			endcase
		end
	end

	// Destination and flags register in one edge
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			state_q <= STATE_RST;
		else
			state_q <= state_d;
	end

	assign regRdData   = state_q.rdData;
	assign resultData  = state_q.result;
	assign resultValid = state_q.resValid;
	assign flagsOut    = state_q.flags;
	assign winPtrA     = state_q.ptrA;
	assign winPtrB     = state_q.ptrB;
	assign stopMode    = state_q.stop;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);

	sequence sqGo(logic [7:0] code);
		opGo && opCode == code;
	endsequence

	sequence sqMinus;
		opGo && (opCode inside {[alu_slice_pkg::OP_MINUS_LO : alu_slice_pkg::OP_MINUS_HI]});
	endsequence

	sequence sqMinusCy;
		opGo && (opCode inside {[alu_slice_pkg::OP_MINUS_CY_LO : alu_slice_pkg::OP_MINUS_CY_HI]});
	endsequence

	chk_plain_rotate: assert property (sqGo(alu_slice_pkg::OP_ROT_PLAIN_R) or sqGo(alu_slice_pkg::OP_ROT_PLAIN_IR)
		|=> resultValid && resultData == (($past(dstIn) >> 1) | ($past(dstIn) << 7))
		&& flagsOut[alu_slice_pkg::FLAG_CY] == resultData[7])
		else $error("plain rotate result or carry wrong");

	chk_carry_rotate: assert property (sqGo(alu_slice_pkg::OP_ROT_CY_R) or sqGo(alu_slice_pkg::OP_ROT_CY_IR)
		|=> resultData[6:0] == $past(dstIn[7:1]) && resultData[7] == $past(flagsOut[alu_slice_pkg::FLAG_CY])
		&& flagsOut[alu_slice_pkg::FLAG_CY] == $past(dstIn[0]))
		else $error("carry rotate result wrong");

	chk_rotate_flags: assert property (sqGo(alu_slice_pkg::OP_ROT_CY_R)
		|=> flagsOut[alu_slice_pkg::FLAG_SG] == resultData[7]
		&& flagsOut[alu_slice_pkg::FLAG_OV] == (resultData[7] != $past(dstIn[7]))
		&& flagsOut[3:2] == $past(flagsOut[3:2]))
		else $error("carry rotate flags wrong");

	chk_bank_select: assert property (sqGo(alu_slice_pkg::OP_BANK_ZERO) or sqGo(alu_slice_pkg::OP_BANK_ONE)
		|=> flagsOut[alu_slice_pkg::FLAG_BANK] == $past(opCode[4]) && flagsOut[7:1] == $past(flagsOut[7:1])
		&& !resultValid)
		else $error("bank select wrong");

	chk_minus_carry: assert property (sqMinusCy
		|=> resultData == $past(dstIn) - $past(srcIn) - {7'h00, $past(flagsOut[alu_slice_pkg::FLAG_CY])}
		&& flagsOut[alu_slice_pkg::FLAG_DA])
		else $error("subtract with carry result wrong");

	chk_minus_value: assert property (sqMinus
		|=> resultValid && resultData == $past(dstIn) - $past(srcIn)
		&& flagsOut[alu_slice_pkg::FLAG_CY] == ($past(dstIn) < $past(srcIn)))
		else $error("subtract result or borrow wrong");

	chk_minus_overflow: assert property (sqMinus or sqMinusCy
		|=> flagsOut[alu_slice_pkg::FLAG_OV] == (($past(dstIn[7]) != $past(srcIn[7]))
		&& (resultData[7] == $past(srcIn[7]))) && flagsOut[alu_slice_pkg::FLAG_ZE] == (resultData == 8'h00))
		else $error("subtract overflow or zero wrong");

	chk_minus_half: assert property (sqMinus
		|=> flagsOut[alu_slice_pkg::FLAG_HC] == ($past(dstIn[3:0]) < $past(srcIn[3:0])))
		else $error("subtract half carry wrong");

	chk_carry_force: assert property (sqGo(alu_slice_pkg::OP_CY_HIGH)
		|=> flagsOut == ($past(flagsOut) | 8'h80))
		else $error("carry force wrong");

	chk_ashift: assert property (sqGo(alu_slice_pkg::OP_ASHIFT_R) or sqGo(alu_slice_pkg::OP_ASHIFT_IR)
		|=> resultData[7] == resultData[6] && resultData[6:0] == $past(dstIn[7:1])
		&& flagsOut[alu_slice_pkg::FLAG_CY] == $past(dstIn[0]) && !flagsOut[alu_slice_pkg::FLAG_OV])
		else $error("arithmetic shift wrong");

	chk_ptr_single: assert property (opGo && opCode == alu_slice_pkg::OP_WIN_PTR_LOAD
		&& srcIn[1:0] == alu_slice_pkg::SEL_PTR_A
		|=> winPtrA[7:3] == $past(srcIn[7:3]) && winPtrB == $past(winPtrB))
		else $error("single pointer load wrong");

	chk_ptr_both: assert property (opGo && opCode == alu_slice_pkg::OP_WIN_PTR_LOAD
		&& srcIn[1:0] == alu_slice_pkg::SEL_BOTH
		|=> winPtrA[7:3] == {$past(srcIn[7:4]), 1'b0} && winPtrB[7:3] == {$past(srcIn[7:4]), 1'b1})
		else $error("dual pointer load wrong");

	chk_stop_hold: assert property (stopMode && !state_q.irqSync
		|=> stopMode && !resultValid && flagsOut == $past(flagsOut) && winPtrA == $past(winPtrA))
		else $error("stop mode state not retained");

	chk_stop_wake: assert property (!stopMode ##1 stopMode ##0 (extIrq [*3])
		|=> !stopMode)
		else $error("stop mode not left on interrupt");

	chk_swap: assert property (sqGo(alu_slice_pkg::OP_SWAP_R)
		|=> resultData == {$past(dstIn[3:0]), $past(dstIn[7:4])}
		&& flagsOut[alu_slice_pkg::FLAG_SG] == resultData[7] && flagsOut[7] == $past(flagsOut[7]))
		else $error("nibble swap wrong");

	chk_update_once: assert property (opGo |=> resultValid == $past(opCode inside {8'hE0, 8'hE1, 8'hC0, 8'hC1,
		8'hD0, 8'hD1, 8'hF0, 8'hF1, [8'h22:8'h26], [8'h32:8'h36]}))
		else $error("result strobe timing wrong");

	// Strobe is one cycle unless another rotate, shift, swap or subtract follows at once
	chk_strobe_idle: assert property (!opGo
		|=> !resultValid)
		else $error("result strobe without instruction");

	chk_plain_flags: assert property (sqGo(alu_slice_pkg::OP_ROT_PLAIN_R) or sqGo(alu_slice_pkg::OP_ROT_PLAIN_IR)
		|=> flagsOut[alu_slice_pkg::FLAG_ZE] == (resultData == 8'h00) && flagsOut[alu_slice_pkg::FLAG_SG] == resultData[7]
		&& flagsOut[alu_slice_pkg::FLAG_OV] == (resultData[7] != $past(dstIn[7])) && flagsOut[3:0] == $past(flagsOut[3:0]))
		else $error("plain rotate flags wrong");

	chk_rotate_ir_flags: assert property (sqGo(alu_slice_pkg::OP_ROT_CY_IR)
		|=> flagsOut[alu_slice_pkg::FLAG_ZE] == (resultData == 8'h00) && flagsOut[alu_slice_pkg::FLAG_SG] == resultData[7]
		&& flagsOut[3:0] == $past(flagsOut[3:0]))
		else $error("indirect carry rotate flags wrong");

	chk_ashift_flags: assert property (sqGo(alu_slice_pkg::OP_ASHIFT_R) or sqGo(alu_slice_pkg::OP_ASHIFT_IR)
		|=> flagsOut[alu_slice_pkg::FLAG_ZE] == (resultData == 8'h00) && flagsOut[alu_slice_pkg::FLAG_SG] == resultData[7]
		&& flagsOut[3:0] == $past(flagsOut[3:0]) && resultValid)
		else $error("arithmetic shift flags wrong");

	chk_swap_flags: assert property (sqGo(alu_slice_pkg::OP_SWAP_R) or sqGo(alu_slice_pkg::OP_SWAP_IR)
		|=> resultValid && flagsOut[alu_slice_pkg::FLAG_ZE] == (resultData == 8'h00)
		&& flagsOut[4:0] == $past(flagsOut[4:0]))
		else $error("nibble swap flags wrong");

	chk_minus_cy_borrow: assert property (sqMinusCy
		|=> flagsOut[alu_slice_pkg::FLAG_CY] == ({1'b0, $past(dstIn)} < ({1'b0, $past(srcIn)}
		+ {8'h00, $past(flagsOut[alu_slice_pkg::FLAG_CY])})) && resultValid
		&& flagsOut[alu_slice_pkg::FLAG_SG] == resultData[7])
		else $error("subtract with carry borrow wrong");

	chk_flag_only: assert property (sqGo(alu_slice_pkg::OP_CY_HIGH)
		|=> !resultValid && winPtrA == $past(winPtrA) && winPtrB == $past(winPtrB))
		else $error("carry force touched other state");

	chk_ptr_b_single: assert property (opGo && opCode == alu_slice_pkg::OP_WIN_PTR_LOAD
		&& srcIn[1:0] == alu_slice_pkg::SEL_PTR_B
		|=> winPtrB[7:3] == $past(srcIn[7:3]) && winPtrA == $past(winPtrA))
		else $error("second pointer load wrong");

	chk_ptr_none: assert property (opGo && opCode == alu_slice_pkg::OP_WIN_PTR_LOAD && srcIn[1:0] == 2'h3
		|=> winPtrA == $past(winPtrA) && winPtrB == $past(winPtrB))
		else $error("pointer changed on unused select");

	chk_ptr_low_kept: assert property (opGo && opCode == alu_slice_pkg::OP_WIN_PTR_LOAD
		|=> winPtrA[2:0] == $past(winPtrA[2:0]) && winPtrB[2:0] == $past(winPtrB[2:0]))
		else $error("pointer low bits changed");

	chk_stop_enter: assert property (sqGo(alu_slice_pkg::OP_HALT)
		|=> stopMode && !resultValid)
		else $error("stop mode not entered");

	// Register port checks
	chk_write_stopped: assert property (regWrEn && stopMode
		|=> flagsOut == $past(flagsOut) && winPtrA == $past(winPtrA) && winPtrB == $past(winPtrB))
		else $error("register write accepted in stop mode");

	chk_read_status: assert property (regRdEn && regAddr == alu_slice_pkg::REG_STATUS
		|=> regRdData == {7'h00, $past(stopMode)})
		else $error("status read wrong");

	chk_read_flags: assert property (regRdEn && regAddr == alu_slice_pkg::REG_FLAGS
		|=> regRdData == $past(flagsOut))
		else $error("flag register read wrong");

	chk_read_idle: assert property (!regRdEn
		|=> regRdData == 8'h00)
		else $error("read data outside read cycle");

	chk_write_ptr: assert property (regWrEn && !opGo && !stopMode && regAddr == alu_slice_pkg::REG_PTR_A
		|=> winPtrA == $past(regWrData))
		else $error("pointer write wrong");

endmodule

// ---- hw/alu_slice_pkg.sv ----
package alu_slice_pkg;

	// Opcodes of the slice
	localparam logic [7:0] OP_ROT_PLAIN_R   = 8'hE0;
	localparam logic [7:0] OP_ROT_PLAIN_IR  = 8'hE1;
	localparam logic [7:0] OP_ROT_CY_R      = 8'hC0;
	localparam logic [7:0] OP_ROT_CY_IR     = 8'hC1;
	localparam logic [7:0] OP_ASHIFT_R      = 8'hD0;
	localparam logic [7:0] OP_ASHIFT_IR     = 8'hD1;
	localparam logic [7:0] OP_SWAP_R        = 8'hF0;
	localparam logic [7:0] OP_SWAP_IR       = 8'hF1;
	localparam logic [7:0] OP_MINUS_LO      = 8'h22;
	localparam logic [7:0] OP_MINUS_HI      = 8'h26;
	localparam logic [7:0] OP_MINUS_CY_LO   = 8'h32;
	localparam logic [7:0] OP_MINUS_CY_HI   = 8'h36;
	localparam logic [7:0] OP_BANK_ZERO     = 8'h4F;
	localparam logic [7:0] OP_BANK_ONE      = 8'h5F;
	localparam logic [7:0] OP_CY_HIGH       = 8'hDF;
	localparam logic [7:0] OP_WIN_PTR_LOAD  = 8'h31;
	localparam logic [7:0] OP_HALT          = 8'h7F;

	// Flag register layout
	localparam int unsigned FLAG_CY   = 7;
	localparam int unsigned FLAG_ZE   = 6;
	localparam int unsigned FLAG_SG   = 5;
	localparam int unsigned FLAG_OV   = 4;
	localparam int unsigned FLAG_DA   = 3;
	localparam int unsigned FLAG_HC   = 2;
	localparam int unsigned FLAG_BANK = 0;

	// Window pointer select codes in source bits 1:0
	localparam logic [1:0] SEL_BOTH  = 2'h0;
	localparam logic [1:0] SEL_PTR_B = 2'h1;
	localparam logic [1:0] SEL_PTR_A = 2'h2;

	// Register port offsets
	localparam logic [3:0] REG_FLAGS  = 4'h0;
	localparam logic [3:0] REG_PTR_A  = 4'h1;
	localparam logic [3:0] REG_PTR_B  = 4'h2;
	localparam logic [3:0] REG_STATUS = 4'h3;
	localparam int unsigned STAT_STOP = 0;

	// Reset values
	localparam logic [7:0] FLAGS_RST = 8'h00;
	localparam logic [7:0] PTR_A_RST = 8'hC0;
	localparam logic [7:0] PTR_B_RST = 8'hC8;

endpackage

// ---- sim/testbench.sv ----
`timescale 1ns/10ps
module testbench;
	logic       clk_sys;
	logic       sys_rst;
	logic       opValid;
	logic [7:0] opCode;
	logic [7:0] dstIn;
	logic [7:0] srcIn;
	logic       extIrq;
	logic [3:0] regAddr;
	logic [7:0] regWrData;
	logic       regWrEn;
	logic       regRdEn;
	logic [7:0] regRdData;
	logic [7:0] resultData;
	logic       resultValid;
	logic [7:0] flagsOut;
	logic [7:0] winPtrA;
	logic [7:0] winPtrB;
	logic       stopMode;
	logic [7:0] expF, expA, expB, expR, expRd, nf, r, v, a;
	logic       expRv, expStop, irq1, irq2, armed, st, cin;
	logic [8:0] diff;
	logic [4:0] nib;
	int         failures = 0;
	int         compares = 0;
	int         cycles = 0;
	integer     seed = 32'h2f5ed175;

	rotate_shift_subtract_alu dut
	(
		.clk_sys     (clk_sys),
		.sys_rst     (sys_rst),
		.opValid     (opValid),
		.opCode      (opCode),
		.dstIn       (dstIn),
		.srcIn       (srcIn),
		.extIrq      (extIrq),
		.regAddr     (regAddr),
		.regWrData   (regWrData),
		.regWrEn     (regWrEn),
		.regRdEn     (regRdEn),
		.regRdData   (regRdData),
		.resultData  (resultData),
		.resultValid (resultValid),
		.flagsOut    (flagsOut),
		.winPtrA     (winPtrA),
		.winPtrB     (winPtrB),
		.stopMode    (stopMode)
	);

	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	function automatic logic [7:0] rnd();
		return 8'($random(seed));
	endfunction

	task check(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp)
		begin
			failures++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task final_report();
		$display("compares=%0d failures=%0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Bus tasks are entered at a rising edge and return at the next one
	task op(input logic [7:0] c, input logic [7:0] d, input logic [7:0] s);
		opValid <= 1'b1; opCode <= c; dstIn <= d; srcIn <= s;
		regWrEn <= 1'b0; regRdEn <= 1'b0;
		@(posedge clk_sys);
	endtask

	task rd(input logic [3:0] ad);
		opValid <= 1'b0; regWrEn <= 1'b0; regRdEn <= 1'b1; regAddr <= ad;
		@(posedge clk_sys);
	endtask

	task wr(input logic [3:0] ad, input logic [7:0] d);
		opValid <= 1'b0; regRdEn <= 1'b0; regWrEn <= 1'b1; regAddr <= ad; regWrData <= d;
		@(posedge clk_sys);
	endtask

	task idle();
		opValid <= 1'b0; regWrEn <= 1'b0; regRdEn <= 1'b0;
		@(posedge clk_sys);
	endtask

	// Mirror of the block: sees inputs as sampled at each rising edge
	always @(posedge clk_sys)
	begin
		armed = 1'b1;
		if (sys_rst)
		begin
			expF = alu_slice_pkg::FLAGS_RST; expA = alu_slice_pkg::PTR_A_RST; expB = alu_slice_pkg::PTR_B_RST;
			expR = 8'h00; expRd = 8'h00; expRv = 1'b0; expStop = 1'b0; irq1 = 1'b0; irq2 = 1'b0;
		end
		else
		begin
			st = expStop;
			expRv = 1'b0;
			cin = expF[alu_slice_pkg::FLAG_CY];
			expRd = !regRdEn ? 8'h00 : regAddr == alu_slice_pkg::REG_FLAGS ? expF :
				regAddr == alu_slice_pkg::REG_PTR_A ? expA : regAddr == alu_slice_pkg::REG_PTR_B ? expB :
				regAddr == alu_slice_pkg::REG_STATUS ? {7'h00, st} : 8'h00;
			if (regWrEn && !st && regAddr == alu_slice_pkg::REG_FLAGS) expF = regWrData;
			if (regWrEn && !st && regAddr == alu_slice_pkg::REG_PTR_A) expA = regWrData;
			if (regWrEn && !st && regAddr == alu_slice_pkg::REG_PTR_B) expB = regWrData;
			if (st && irq2) expStop = 1'b0;
			irq2 = irq1;
			irq1 = extIrq;
			if (opValid && !st)
			begin
				nf = expF;
				expRv = 1'b1;
				case (opCode) inside
					8'hE0, 8'hE1: r = {dstIn[0], dstIn[7:1]};
					8'hC0, 8'hC1: r = {cin, dstIn[7:1]};
					8'hD0, 8'hD1: r = {dstIn[7], dstIn[7:1]};
					8'hF0, 8'hF1: r = {dstIn[3:0], dstIn[7:4]};
					[8'h22:8'h26], [8'h32:8'h36]:
					begin
						diff = {1'b0, dstIn} - {1'b0, srcIn} - 9'(opCode[4] & cin);
						nib = {1'b0, dstIn[3:0]} - {1'b0, srcIn[3:0]} - 5'(opCode[4] & cin);
						r = diff[7:0];
						nf[alu_slice_pkg::FLAG_CY] = diff[8];
						nf[alu_slice_pkg::FLAG_HC] = nib[4];
						nf[alu_slice_pkg::FLAG_OV] = (dstIn[7] ^ srcIn[7]) & ~(r[7] ^ srcIn[7]);
						nf[alu_slice_pkg::FLAG_DA] = 1'b1;
					end
					8'h4F: nf[alu_slice_pkg::FLAG_BANK] = 1'b0;
					8'h5F: nf[alu_slice_pkg::FLAG_BANK] = 1'b1;
					8'hDF: nf[alu_slice_pkg::FLAG_CY] = 1'b1;
					8'h7F: expStop = 1'b1;
					8'h31:
					begin
						if (srcIn[1:0] == alu_slice_pkg::SEL_BOTH) expA = {srcIn[7:4], 1'b0, expA[2:0]};
						if (srcIn[1:0] == alu_slice_pkg::SEL_BOTH) expB = {srcIn[7:4], 1'b1, expB[2:0]};
						if (srcIn[1:0] == alu_slice_pkg::SEL_PTR_A) expA = {srcIn[7:3], expA[2:0]};
						if (srcIn[1:0] == alu_slice_pkg::SEL_PTR_B) expB = {srcIn[7:3], expB[2:0]};
					end
					default: ;
				endcase
				// Only rotates, shift, swap and subtracts produce a result
				expRv = opCode inside {8'hE0, 8'hE1, 8'hC0, 8'hC1, 8'hD0, 8'hD1, 8'hF0, 8'hF1, [8'h22:8'h26], [8'h32:8'h36]};
				if (opCode inside {8'hE0, 8'hE1, 8'hC0, 8'hC1, 8'hD0, 8'hD1})
				begin
					nf[alu_slice_pkg::FLAG_CY] = dstIn[0];
					nf[alu_slice_pkg::FLAG_OV] = r[7] ^ dstIn[7];
				end
				if (expRv) nf[alu_slice_pkg::FLAG_ZE] = (r == 8'h00);
				if (expRv) nf[alu_slice_pkg::FLAG_SG] = r[7];
				if (expRv) expR = r;
				expF = nf;
			end
		end
	end

	always @(negedge clk_sys)
		if (armed)
		begin
			check(resultData, expR);
			check(resultValid, expRv);
			check(flagsOut, expF);
			check(winPtrA, expA);
			check(winPtrB, expB);
			check(stopMode, expStop);
			check(regRdData, expRd);
		end

	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 10000)
		begin
			failures++;
			final_report();
		end
	end

	initial
	begin
		sys_rst = 1'b1; opValid = 1'b0; opCode = 8'h00; dstIn = 8'h00; srcIn = 8'h00; extIrq = 1'b0;
		regAddr = 4'h0; regWrData = 8'h00; regWrEn = 1'b0; regRdEn = 1'b0; armed = 1'b0;
		repeat (2) @(posedge clk_sys);
		sys_rst <= 1'b0;
		wr(4'h3, 8'hFF);
		for (int i = 0; i < 16; i++) rd(i[3:0]);
		$display("test registers done");
		wr(4'h0, 8'hFF);
		for (int i = 0; i < 256; i++) if (i != 8'h7F) op(i[7:0], rnd(), rnd());
		op(8'h22, 8'h12, 8'h03);
		op(8'hDF, 8'h00, 8'h00);
		op(8'h32, 8'h01, 8'h8A);
		op(8'hC0, 8'h55, 8'h00);
		op(8'hE0, 8'h31, 8'h00);
		op(8'hD0, 8'h9A, 8'h00);
		op(8'hF0, 8'h3E, 8'h00);
		for (int i = 0; i < 4; i++) op(8'h31, 8'h00, (rnd() & 8'hFC) | 8'(i));
		$display("test opcodes done");
		op(8'h7F, 8'h00, 8'h00);
		op(8'hE0, 8'h81, 8'h00);
		wr(4'h1, 8'h50);
		idle();
		extIrq <= 1'b1;
		repeat (5) idle();
		extIrq <= 1'b0;
		op(8'h7F, 8'h00, 8'h00);
		extIrq <= 1'b1;
		repeat (4) idle();
		extIrq <= 1'b0;
		op(8'h7F, 8'h00, 8'h00);
		idle();
		sys_rst <= 1'b1;
		repeat (2) idle();
		sys_rst <= 1'b0;
		$display("test stop done");
		repeat (3000)
		begin
			v = rnd();
			a = rnd();
			if (v[7:3] == 5'h00) extIrq <= ~extIrq;
			if (v[1:0] == 2'h0) op(rnd(), rnd(), rnd());
			else if (v[1:0] == 2'h1) rd(a[3:0]);
			else if (v[1:0] == 2'h2) wr(a[3:0], (a[3:0] inside {4'h1, 4'h2}) ? (rnd() & 8'hF8) : rnd());
			else idle();
		end
		$display("test random done");
		final_report();
	end
endmodule
